// File: verilog/scc_map.svh
// Constants of the snooping coherence block: widths, sizes and fields.
// Assumes inclusion by the package, the design modules and the bench.
`ifndef SCC_MAP_SVH
`define SCC_MAP_SVH
// Block address width on the bus (byte address bits 39:6).
`define SCC_BLK_W 34
// Cache index width; the cache holds 2**SCC_IDX_W lines.
`define SCC_IDX_W 4
// Number of cache lines.
`define SCC_LINES 16
// Tag width: block bits 33:1 minus the index.
`define SCC_TAG_W 29
// Lowest block bit of the index; bit 0 only selects the subblock.
`define SCC_IDX_LSB 1
`endif

// File: verilog/scc_pkg.sv
// Types of the snooping coherence block.
// Assumes scc_map.svh is on the include path.
`include "scc_map.svh"
package scc_pkg;
  // Bus operation codes, encoded 0 upward in this order.
  typedef enum logic [2:0] {
    SCC_OP_READ, SCC_OP_WRITE, SCC_OP_WR_VICTIM, SCC_OP_RD_CSR, SCC_OP_WR_CSR
  } scc_op_t;
  // Local request kinds, encoded 0 upward in this order.
  typedef enum logic [1:0] {SCC_LCL_READ, SCC_LCL_WRITE, SCC_LCL_FILL} scc_lcl_t;
  // One observed bus command cycle.
  typedef struct packed {
    logic                  valid;
    logic                  own;
    scc_op_t               op;
    logic [`SCC_BLK_W-1:0] blk;
  } scc_bus_cmd_t;
  // One line of tag and state.
  typedef struct packed {
    logic                  v;
    logic                  s;
    logic                  d;
    logic [`SCC_TAG_W-1:0] tag;
  } scc_line_t;
endpackage : scc_pkg

// File: verilog/scc_tag_store.sv
// Tag and state store with two read ports and two write ports.
// Assumes the caller never needs both writes on one index in one cycle;
// if it happens, the snoop write wins.
`timescale 1ns/1ps
`include "scc_map.svh"
module scc_tag_store (
  // Clock and reset.
  input  wire logic                  core_clk,
  input  wire logic                  srst,
  // Snoop port.
  input  wire logic [`SCC_IDX_W-1:0] snp_idx,
  output scc_pkg::scc_line_t         snp_line,
  input  wire logic                  snp_we,
  input  scc_pkg::scc_line_t         snp_wline,
  // Local port.
  input  wire logic [`SCC_IDX_W-1:0] lcl_idx,
  output scc_pkg::scc_line_t         lcl_line,
  input  wire logic                  lcl_we,
  input  scc_pkg::scc_line_t         lcl_wline
);
  // The lines themselves.
  scc_pkg::scc_line_t mem [`SCC_LINES];

  // Read ports are combinational.
  assign snp_line = mem[snp_idx];
  assign lcl_line = mem[lcl_idx];

  // Reset clears every line to invalid; snoop write has priority.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      for (int i = 0; i < `SCC_LINES; i++) begin
        mem[i] <= '0;
      end
    end else begin
      if (lcl_we && !(snp_we && snp_idx == lcl_idx)) begin
        mem[lcl_idx] <= lcl_wline;
      end
      if (snp_we) begin
        mem[snp_idx] <= snp_wline;
      end
    end
  end
endmodule : scc_tag_store

// File: verilog/scc_snoop.sv
// Snooping coherence logic of a write-update cache node.
// Assumes bus pins arrive unsynchronised and the local port is on core_clk.
`timescale 1ns/1ps
`include "scc_map.svh"
module scc_snoop (
  // Clock and reset.
  input  wire logic                  core_clk,
  input  wire logic                  srst,
  // Configuration: invalidate rather than update on a snooped write.
  input  wire logic                  cfg_inval_on_write,
  // Observed bus command (pins, synchronised here).
  input  scc_pkg::scc_bus_cmd_t      bus_cmd,
  // Wired response lines and data supply.
  output logic                       shared_out,
  output logic                       dirty_out,
  output logic                       supply_data,
  output logic [`SCC_BLK_W-1:0]      supply_blk,
  // Local processor requests.
  input  wire logic                  lcl_valid,
  input  scc_pkg::scc_lcl_t          lcl_kind,
  input  wire logic [`SCC_BLK_W-1:0] lcl_blk,
  input  wire logic                  fill_shared,
  input  wire logic                  fill_dirty,
  // Local answers.
  output logic                       lcl_done,
  output logic                       lcl_hit,
  output logic                       lcl_dirty,
  output logic                       lcl_bcast,
  output logic                       lcl_retry,
  output logic                       victim_valid,
  output logic [`SCC_BLK_W-1:0]      victim_blk
);
  // ---------------------------------------------------------------
  // Decode functions
  // ---------------------------------------------------------------
  // True for operations that other caches must probe.
  function automatic logic probe_op(input scc_pkg::scc_op_t op);
    probe_op = (op == scc_pkg::SCC_OP_READ) || (op == scc_pkg::SCC_OP_WRITE);
  endfunction : probe_op
  // Index of a block address.
  function automatic logic [`SCC_IDX_W-1:0] idx_of(input logic [`SCC_BLK_W-1:0] b);
    idx_of = b[`SCC_IDX_LSB +: `SCC_IDX_W];
  endfunction : idx_of

  // Tag of a block address.
  function automatic logic [`SCC_TAG_W-1:0] tag_of(input logic [`SCC_BLK_W-1:0] b);
    tag_of = b[`SCC_BLK_W-1 -: `SCC_TAG_W];
  endfunction : tag_of

  // Read hit: tag match and valid, other bits ignored.
  function automatic logic rd_hit(input scc_pkg::scc_line_t l,
                                  input logic [`SCC_TAG_W-1:0] t);
    rd_hit = l.v && (l.tag == t);
  endfunction : rd_hit

  // ---------------------------------------------------------------
  // Bus input synchroniser
  // ---------------------------------------------------------------
  scc_pkg::scc_bus_cmd_t bus_meta;  // First stage, read only by the second.
  scc_pkg::scc_bus_cmd_t bus_sync;  // Second stage, used by the probe.

  // Two flip-flops before any logic looks at the bus pins.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      bus_meta <= '0;
      bus_sync <= '0;
    end else begin
      bus_meta <= bus_cmd;
      bus_sync <= bus_meta;
    end
  end

  // ---------------------------------------------------------------
  // Tag store
  // ---------------------------------------------------------------
  scc_pkg::scc_line_t snp_line;    // Line under the snooped address.
  scc_pkg::scc_line_t lcl_line;    // Line under the local address.
  scc_pkg::scc_line_t snp_wline;   // New snooped line state.
  scc_pkg::scc_line_t lcl_wline;   // New local line state.
  logic               snp_we;      // Snoop writes the store.
  logic               lcl_we;      // Local side writes the store.

  // Per-line tag plus valid, shared and dirty bits.
  scc_tag_store u_store (
    .core_clk  (core_clk),
    .srst      (srst),
    .snp_idx   (idx_of(bus_sync.blk)),
    .snp_line  (snp_line),
    .snp_we    (snp_we),
    .snp_wline (snp_wline),
    .lcl_idx   (idx_of(lcl_blk)),
    .lcl_line  (lcl_line),
    .lcl_we    (lcl_we),
    .lcl_wline (lcl_wline)
  );

  // ---------------------------------------------------------------
  // Snoop response
  // ---------------------------------------------------------------
  logic                  snp_probe;    // An eligible foreign operation.
  logic                  snp_hit;      // Probe found a valid copy.
  logic                  snp_read;     // Operation is a read.
  logic                  own_wr;       // Our own bus write is seen.
  logic                  next_shared;  // Next shared response.
  logic                  next_dirty;   // Next dirty response.
  logic [`SCC_BLK_W-1:0] next_sblk;    // Next supplied block.

  // Probe the store and work out responses and new line state.
  always_comb begin
    snp_probe   = bus_sync.valid && !bus_sync.own && probe_op(bus_sync.op);
    snp_hit     = snp_probe && rd_hit(snp_line, tag_of(bus_sync.blk));
    snp_read    = bus_sync.op == scc_pkg::SCC_OP_READ;
    own_wr      = bus_sync.valid && bus_sync.own && bus_sync.op == scc_pkg::SCC_OP_WRITE
                  && rd_hit(snp_line, tag_of(bus_sync.blk));
    next_shared = 1'b0;
    next_dirty  = 1'b0;
    next_sblk   = supply_blk;
    snp_we      = 1'b0;
    snp_wline   = snp_line;
    if (snp_hit && snp_read) begin
      // Read hit: report a copy; a modified copy also supplies data.
      next_shared = 1'b1;
      next_dirty  = snp_line.d;
      next_sblk   = bus_sync.blk;
      snp_we      = 1'b1;
      snp_wline.s = 1'b1;
    end else if (snp_hit) begin
      snp_we = 1'b1;
      if (cfg_inval_on_write) begin
        // Take the invalidate and stay silent.
        snp_wline.v = 1'b0;
      end else begin
        // Take the update: shared and clean.
        next_shared = 1'b1;
        snp_wline.s = 1'b1;
        snp_wline.d = 1'b0;
      end
    end else if (own_wr) begin
      // Our own broadcast write cleans our copy.
      snp_we      = 1'b1;
      snp_wline.d = 1'b0;
    end
  end

  // Register the wired responses.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      shared_out  <= 1'b0;
      dirty_out   <= 1'b0;
      supply_data <= 1'b0;
      supply_blk  <= '0;
    end else begin
      shared_out  <= next_shared;
      dirty_out   <= next_dirty;
      supply_data <= next_dirty;
      supply_blk  <= next_sblk;
    end
  end

  // ---------------------------------------------------------------
  // Local probe, update and fill
  // ---------------------------------------------------------------
  logic                  l_match;      // Local read hit.
  logic                  l_conf;       // Snoop takes the same line now.
  logic                  next_done;    // Request answered.
  logic                  next_hit;     // Probe satisfied.
  logic                  next_ldirty;  // Line differs from memory.
  logic                  next_bcast;   // Write must go on the bus.
  logic                  next_retry;   // Request refused, reissue.
  logic                  next_vict;    // Victim write needed.
  logic [`SCC_BLK_W-1:0] next_vblk;    // Victim block address.

  // Evaluate the local request against the store.
  always_comb begin
    l_match     = rd_hit(lcl_line, tag_of(lcl_blk));
    l_conf      = snp_we && idx_of(bus_sync.blk) == idx_of(lcl_blk);
    next_done   = 1'b0;
    next_hit    = 1'b0;
    next_ldirty = 1'b0;
    next_bcast  = 1'b0;
    next_retry  = 1'b0;
    next_vict   = 1'b0;
    next_vblk   = victim_blk;
    lcl_we      = 1'b0;
    lcl_wline   = lcl_line;
    if (lcl_valid && l_conf) begin
      // The snoop owns the line this cycle.
      next_done  = 1'b1;
      next_retry = 1'b1;
    end else if (lcl_valid) begin
      next_done = 1'b1;
      case (lcl_kind)
        scc_pkg::SCC_LCL_READ: begin
          next_hit    = l_match;
          next_ldirty = l_match && lcl_line.d;
        end
        scc_pkg::SCC_LCL_WRITE: begin
          // Exclusive line: write locally and mark modified.
          next_hit    = l_match && !lcl_line.s;
          next_bcast  = l_match && lcl_line.s;
          next_ldirty = next_hit || (l_match && lcl_line.d);
          lcl_we      = next_hit;
          lcl_wline.d = 1'b1;
        end
        scc_pkg::SCC_LCL_FILL: begin
          // Install the line; a displaced dirty line becomes a victim.
          next_vict   = lcl_line.v && lcl_line.d && !l_match;
          next_vblk   = {lcl_line.tag, idx_of(lcl_blk), 1'b0};
          lcl_we      = 1'b1;
          lcl_wline.v = 1'b1;
          lcl_wline.s = fill_shared;
          lcl_wline.d = fill_dirty;
          lcl_wline.tag = tag_of(lcl_blk);
        end
        default: begin
          next_done = 1'b1;
        end
      endcase
    end
  end

  // Register the local answers.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      lcl_done     <= 1'b0;
      lcl_hit      <= 1'b0;
      lcl_dirty    <= 1'b0;
      lcl_bcast    <= 1'b0;
      lcl_retry    <= 1'b0;
      victim_valid <= 1'b0;
      victim_blk   <= '0;
    end else begin
      lcl_done     <= next_done;
      lcl_hit      <= next_hit;
      lcl_dirty    <= next_ldirty;
      lcl_bcast    <= next_bcast;
      lcl_retry    <= next_retry;
      victim_valid <= next_vict;
      victim_blk   <= next_vblk;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  // A foreign operation that is not probed.
  sequence s_unprobed;
    bus_sync.valid && !bus_sync.own && !probe_op(bus_sync.op);
  endsequence

  chk_no_probe_op: assert property (s_unprobed |=> !shared_out && !dirty_out)
    else $error("Unprobed operation drew a response.");
  chk_shared_hit: assert property (snp_hit && snp_read |=> shared_out)
    else $error("Read hit did not assert shared.");
  chk_inval_write: assert property (snp_hit && !snp_read && cfg_inval_on_write
      |=> !shared_out ##1 !rd_hit(u_store.mem[$past(idx_of(bus_sync.blk), 2)],
      tag_of($past(bus_sync.blk, 2))))
    else $error("Invalidating write hit left line valid or shared.");
  chk_dirty_resp: assert property (snp_hit && snp_read && snp_line.d
      |=> dirty_out && supply_data && supply_blk == $past(bus_sync.blk))
    else $error("Modified read hit missed dirty or supply.");
  chk_dirty_shared: assert property (dirty_out |-> shared_out && supply_data)
    else $error("Dirty response without shared or supply.");
  chk_rd_valid: assert property (lcl_valid && !l_conf && lcl_kind == scc_pkg::SCC_LCL_READ
      && !lcl_line.v |=> lcl_done && !lcl_hit)
    else $error("Invalid line counted as read hit.");
  chk_wr_shared: assert property (lcl_valid && !l_conf && lcl_kind == scc_pkg::SCC_LCL_WRITE
      && lcl_line.s |=> !lcl_hit)
    else $error("Write to shared line counted as hit.");
  chk_bcast_wr: assert property (lcl_valid && !l_conf && lcl_kind == scc_pkg::SCC_LCL_WRITE
      && l_match && lcl_line.s |=> lcl_bcast [*1] ##1 !lcl_bcast || lcl_valid)
    else $error("Shared write hit not flagged for the bus.");
  chk_victim: assert property (lcl_valid && !l_conf && lcl_kind == scc_pkg::SCC_LCL_FILL
      && lcl_line.v && lcl_line.d && !l_match |=> victim_valid)
    else $error("Displaced dirty line raised no victim.");
  chk_write_clean: assert property ((snp_hit && !snp_read && !cfg_inval_on_write) || own_wr
      |=> !u_store.mem[$past(idx_of(bus_sync.blk))].d)
    else $error("Bus write left the line dirty.");
endmodule : scc_snoop

// File: tb/scc_mem_model.sv
// Far-side model: a memory node that answers bus reads unless a cache claims a modified copy.
// Assumes it sees the same command cycles as the node and the wired modified-copy line.
`timescale 1ns/1ps
module scc_mem_model (
  // Clock and reset.
  input  wire logic             core_clk,
  input  wire logic             srst,
  // Observed bus command and wired modified-copy line.
  input  scc_pkg::scc_bus_cmd_t bus_cmd,
  input  wire logic             dirty_wire,
  // Memory read data strobe, one cycle in the response slot.
  output logic                  mem_data_valid
);
  // ----------------------------------------
  // Read pipeline
  // ----------------------------------------
  logic [2:0] rd_pipe;      // Reads in flight toward the response slot.
  logic [2:0] next_rd_pipe; // Next value of the read pipeline.

  // Shifts in one bit per observed read; the third stage lines up with the cache
  // response, which stands after the third edge counting the sampling edge.
  always_comb begin
    next_rd_pipe = {rd_pipe[1:0], bus_cmd.valid && (bus_cmd.op == scc_pkg::SCC_OP_READ)};
  end

  // Registers the pipeline; reset empties it.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      rd_pipe <= 3'h0;
    end else begin
      rd_pipe <= next_rd_pipe;
    end
  end

  // Data is withheld whenever a cache claims the modified copy.
  // This node never drives the modified-copy line, so only one node can.
  assign mem_data_valid = rd_pipe[2] && !dirty_wire;
endmodule : scc_mem_model

// File: tb/scc_snoop_tb.sv
// Self-checking bench for the snooping coherence node with a memory model on the bus.
// Assumes scc_map.svh on the include path and the package compiled first.
`timescale 1ns/1ps
`include "scc_map.svh"
`define CHK(name, exp, got) begin \
  total_checks++; \
  if ((got) !== (exp)) begin \
    errors++; \
    $display("[ERR] %s expected %h seen %h", name, exp, got); \
  end \
end
module scc_snoop_tb;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic                  core_clk, srst, cfg_inval_on_write;
  scc_pkg::scc_bus_cmd_t bus_cmd;
  logic                  shared_out, dirty_out, supply_data, mem_data_valid;
  logic [`SCC_BLK_W-1:0] supply_blk, lcl_blk, victim_blk;
  logic                  lcl_valid, fill_shared, fill_dirty;
  scc_pkg::scc_lcl_t     lcl_kind;
  logic                  lcl_done, lcl_hit, lcl_dirty, lcl_bcast, lcl_retry, victim_valid;
  int                    errors, total_checks;
  // Two blocks on one index with different tags; bit 0 only picks the subblock.
  localparam logic [`SCC_BLK_W-1:0] blk_a = 34'h0_1234_5674;
  localparam logic [`SCC_BLK_W-1:0] blk_b = 34'h0_1234_5694;

  scc_snoop uut (.core_clk(core_clk), .srst(srst), .cfg_inval_on_write(cfg_inval_on_write),
    .bus_cmd(bus_cmd), .shared_out(shared_out), .dirty_out(dirty_out),
    .supply_data(supply_data), .supply_blk(supply_blk), .lcl_valid(lcl_valid),
    .lcl_kind(lcl_kind), .lcl_blk(lcl_blk), .fill_shared(fill_shared), .fill_dirty(fill_dirty),
    .lcl_done(lcl_done), .lcl_hit(lcl_hit), .lcl_dirty(lcl_dirty), .lcl_bcast(lcl_bcast),
    .lcl_retry(lcl_retry), .victim_valid(victim_valid), .victim_blk(victim_blk));

  // The node is the only cache here, so the wired line is its own output.
  scc_mem_model mem (.core_clk(core_clk), .srst(srst), .bus_cmd(bus_cmd),
    .dirty_wire(dirty_out), .mem_data_valid(mem_data_valid));

  // Free-running 100 MHz clock.
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // ----------------------------------------
  // Bus and local drivers
  // ----------------------------------------
  // Moves to just after the next rising edge, where inputs change.
  task automatic tick;
    @(posedge core_clk);
    #1;
  endtask : tick

  // One local request; the answer stands one cycle after the request edge.
  task automatic lcl(input scc_pkg::scc_lcl_t k, input logic [`SCC_BLK_W-1:0] b,
                     input logic fs, input logic fd, input logic ck, input logic eh,
                     input logic ed, input logic eb, input logic ev);
    lcl_valid = 1'b1;
    lcl_kind = k;
    lcl_blk = b;
    fill_shared = fs;
    fill_dirty = fd;
    tick();
    `CHK("lcl_done", 1'b1, lcl_done)
    `CHK("lcl_retry", 1'b0, lcl_retry)
    `CHK("victim_valid", ev, victim_valid)
    if (ev) `CHK("victim_blk", blk_a, victim_blk)
    if (ck) begin
      `CHK("lcl_hit", eh, lcl_hit)
      `CHK("lcl_dirty", ed, lcl_dirty)
      `CHK("lcl_bcast", eb, lcl_bcast)
    end
    lcl_valid = 1'b0;
    tick();
  endtask : lcl

  // One observed bus command; the one-cycle response stands after the third edge,
  // counting the edge that samples the command.
  task automatic snoop(input scc_pkg::scc_op_t op, input logic own,
                       input logic [`SCC_BLK_W-1:0] b, input logic esh, input logic edt);
    bus_cmd = '{valid: 1'b1, own: own, op: op, blk: b};
    tick();
    bus_cmd = '0;
    repeat (2) tick();
    `CHK("shared_out", esh, shared_out)
    `CHK("dirty_out", edt, dirty_out)
    `CHK("supply_data", edt, supply_data)
    if (edt) `CHK("supply_blk", b, supply_blk)
    `CHK("mem_data_valid", (op == scc_pkg::SCC_OP_READ) && !edt, mem_data_valid)
    tick();
  endtask : snoop

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  // Empty cache, then an exclusive clean fill that a local write makes dirty.
  task automatic t_exclusive;
    lcl(scc_pkg::SCC_LCL_READ, blk_a, 0, 0, 1, 0, 0, 0, 0);
    lcl(scc_pkg::SCC_LCL_FILL, blk_a, 0, 0, 0, 0, 0, 0, 0);
    lcl(scc_pkg::SCC_LCL_READ, blk_a, 0, 0, 1, 1, 0, 0, 0);
    lcl(scc_pkg::SCC_LCL_WRITE, blk_a, 0, 0, 1, 1, 1, 0, 0);
  endtask : t_exclusive

  // Foreign read of the dirty line: this node answers and supplies, memory holds back.
  task automatic t_dirty_read;
    snoop(scc_pkg::SCC_OP_READ, 0, blk_a | 34'h1, 1, 1);
    lcl(scc_pkg::SCC_LCL_WRITE, blk_a, 0, 0, 1, 0, 1, 1, 0);
    snoop(scc_pkg::SCC_OP_WRITE, 1, blk_a, 0, 0);
    lcl(scc_pkg::SCC_LCL_READ, blk_a, 0, 0, 1, 1, 0, 0, 0);
    snoop(scc_pkg::SCC_OP_READ, 0, blk_a, 1, 0);
  endtask : t_dirty_read

  // An update taken answers shared; unprobed commands, own reads and other tags draw no response.
  task automatic t_ignored;
    scc_pkg::scc_op_t ops[3];
    ops = '{scc_pkg::SCC_OP_WR_VICTIM, scc_pkg::SCC_OP_RD_CSR, scc_pkg::SCC_OP_WR_CSR};
    snoop(scc_pkg::SCC_OP_WRITE, 0, blk_a, 1, 0);
    lcl(scc_pkg::SCC_LCL_READ, blk_a, 0, 0, 1, 1, 0, 0, 0);
    foreach (ops[i]) snoop(ops[i], 0, blk_a, 0, 0);
    snoop(scc_pkg::SCC_OP_READ, 1, blk_a, 0, 0);
    snoop(scc_pkg::SCC_OP_READ, 0, blk_b, 0, 0);
  endtask : t_ignored

  // Invalidate-on-write setting drops the line silently.
  task automatic t_invalidate;
    cfg_inval_on_write = 1'b1;
    snoop(scc_pkg::SCC_OP_WRITE, 0, blk_a, 0, 0);
    lcl(scc_pkg::SCC_LCL_READ, blk_a, 0, 0, 1, 0, 0, 0, 0);
    cfg_inval_on_write = 1'b0;
  endtask : t_invalidate

  // A dirty line displaced by a fill of another tag is reported as a victim.
  task automatic t_victim;
    lcl(scc_pkg::SCC_LCL_FILL, blk_a, 0, 1, 0, 0, 0, 0, 0);
    lcl(scc_pkg::SCC_LCL_FILL, blk_b, 1, 0, 0, 0, 0, 0, 1);
    lcl(scc_pkg::SCC_LCL_READ, blk_b, 0, 0, 1, 1, 0, 0, 0);
    lcl(scc_pkg::SCC_LCL_WRITE, blk_b, 0, 0, 1, 0, 0, 1, 0);
  endtask : t_victim

  // A local read in the cycle a snooped read hit updates the same line is refused.
  task automatic t_retry;
    bus_cmd = '{valid: 1'b1, own: 1'b0, op: scc_pkg::SCC_OP_READ, blk: blk_b};
    tick();
    bus_cmd = '0;
    tick();
    lcl_valid = 1'b1;
    lcl_kind = scc_pkg::SCC_LCL_READ;
    lcl_blk = blk_b;
    tick();
    `CHK("lcl_retry", 1'b1, lcl_retry)
    `CHK("lcl_hit", 1'b0, lcl_hit)
    `CHK("shared_out", 1'b1, shared_out)
    lcl_valid = 1'b0;
    tick();
  endtask : t_retry

  // Prints the counts and the verdict, then ends the run.
  task automatic results;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : results

  // Main sequence: reset for two cycles, then each scenario in turn.
  initial begin
    errors = 0;
    total_checks = 0;
    srst = 1'b1;
    cfg_inval_on_write = 1'b0;
    bus_cmd = '0;
    lcl_valid = 1'b0;
    lcl_kind = scc_pkg::SCC_LCL_READ;
    lcl_blk = '0;
    fill_shared = 1'b0;
    fill_dirty = 1'b0;
    repeat (2) @(posedge core_clk);
    #1 srst = 1'b0;
    tick();
    `CHK("shared_out", 1'b0, shared_out)
    `CHK("lcl_done", 1'b0, lcl_done)
    t_exclusive();
    t_dirty_read();
    t_ignored();
    t_invalidate();
    t_victim();
    t_retry();
    results();
  end

  // Cuts a hung run short and counts it as a mismatch.
  initial begin
    repeat (100000) @(posedge core_clk);
    errors++;
    results();
  end
endmodule : scc_snoop_tb
